//--- ris_defines.vh
`ifndef RIS_DEFINES_VH
`define RIS_DEFINES_VH

// Width of the pin sample bundle
`define RIS_PIN_W      6
// Bit positions inside the pin sample bundle
`define RIS_PIN_CLK    0
`define RIS_PIN_REQ1   1
`define RIS_PIN_REQ2   2
`define RIS_PIN_QUAL1  3
`define RIS_PIN_QUAL2  4
`define RIS_PIN_MODE   5
// Reset values
`define RIS_PIN_RST    6'h00
`define RIS_FF_RST     1'h0
// Mode encoding of the synchronizer select
`define RIS_MODE_TWO   1'h0
`define RIS_MODE_ONE   1'h1

`endif

//--- ris_peer.sv
`timescale 1ns/10ps
module ris_peer (input wire clk_sys, output wire proc_clk);
  reg [3:0] cnt_r = 4'h0;
  // Eight system cycles a phase, so no edge is lost
  always @(negedge clk_sys) cnt_r <= cnt_r + 4'h1;
  assign proc_clk = cnt_r[3];
endmodule // ris_peer

//--- ris_ready_sync.v
`timescale 1ns/10ps
`include "ris_defines.vh"

module ris_ready_sync
(
  clk_sys,
  nrst,
  proc_clk,
  ready_request_one,
  ready_request_two,
  ready_qualifier_one_n,
  ready_qualifier_two_n,
  sync_mode_select,
  ready_out
);

  input  wire clk_sys;
  input  wire nrst;
  input  wire proc_clk;
  input  wire ready_request_one;
  input  wire ready_request_two;
  input  wire ready_qualifier_one_n;
  input  wire ready_qualifier_two_n;
  input  wire sync_mode_select;
  output wire ready_out;

  reg                   clk_meta_r;
  reg                   clk_sync_r;
  reg                   clk_prev_r;
  reg                   req_one_meta_r;
  reg                   req_one_sync_r;
  reg                   req_two_meta_r;
  reg                   req_two_sync_r;
  reg                   qual_one_meta_r;
  reg                   qual_one_sync_r;
  reg                   qual_two_meta_r;
  reg                   qual_two_sync_r;
  reg                   mode_meta_r;
  reg                   mode_sync_r;
  reg                   stage_one_r;
  reg                   stage_two_r;
  reg                   stage_one_nxt;
  reg                   stage_two_nxt;
  wire                  clk_rise;
  wire                  clk_fall;
  wire                  req_one_q;
  wire                  req_two_q;
  wire                  ready_req;
  wire                  mode_now;

  // Qualifiers are active low, as the bus enables are
  function qual_req;
    input req;
    input qual_n;
    begin
      qual_req = req & ~qual_n;
    end
  endfunction

  // Second stage choice made once per falling edge of the processor clock
  function stage_two_next;
    input mode;
    input stage_one;
    input req;
    begin
      if (mode == `RIS_MODE_ONE)
        stage_two_next = req;
      else
        // Deassert goes straight through; assert needs stage one first
        stage_two_next = stage_one & req;
    end
  endfunction

  // Processor clock is foreign to clk_sys; two flops, then edge history
  always @(posedge clk_sys)
  begin
    if (!nrst)
    begin
      clk_meta_r <= `RIS_FF_RST;
      clk_sync_r <= `RIS_FF_RST;
      clk_prev_r <= `RIS_FF_RST;
    end
    else
    begin
      clk_meta_r <= proc_clk;
      clk_sync_r <= clk_meta_r;
      clk_prev_r <= clk_sync_r;
    end
  end

  // Each pin has its own chain so all see the same two-edge latency
  always @(posedge clk_sys)
  begin
    if (!nrst)
    begin
      req_one_meta_r <= `RIS_FF_RST;
      req_one_sync_r <= `RIS_FF_RST;
    end
    else
    begin
      req_one_meta_r <= ready_request_one;
      req_one_sync_r <= req_one_meta_r;
    end
  end

  always @(posedge clk_sys)
  begin
    if (!nrst)
    begin
      req_two_meta_r <= `RIS_FF_RST;
      req_two_sync_r <= `RIS_FF_RST;
    end
    else
    begin
      req_two_meta_r <= ready_request_two;
      req_two_sync_r <= req_two_meta_r;
    end
  end

  always @(posedge clk_sys)
  begin
    if (!nrst)
    begin
      qual_one_meta_r <= `RIS_FF_RST;
      qual_one_sync_r <= `RIS_FF_RST;
    end
    else
    begin
      qual_one_meta_r <= ready_qualifier_one_n;
      qual_one_sync_r <= qual_one_meta_r;
    end
  end

  always @(posedge clk_sys)
  begin
    if (!nrst)
    begin
      qual_two_meta_r <= `RIS_FF_RST;
      qual_two_sync_r <= `RIS_FF_RST;
    end
    else
    begin
      qual_two_meta_r <= ready_qualifier_two_n;
      qual_two_sync_r <= qual_two_meta_r;
    end
  end

  always @(posedge clk_sys)
  begin
    if (!nrst)
    begin
      mode_meta_r <= `RIS_FF_RST;
      mode_sync_r <= `RIS_FF_RST;
    end
    else
    begin
      mode_meta_r <= sync_mode_select;
      mode_sync_r <= mode_meta_r;
    end
  end

  assign clk_rise = clk_sync_r & ~clk_prev_r;
  assign clk_fall = ~clk_sync_r & clk_prev_r;

  assign req_one_q = qual_req(req_one_sync_r, qual_one_sync_r);
  assign req_two_q = qual_req(req_two_sync_r, qual_two_sync_r);
  assign ready_req = req_one_q | req_two_q;
  assign mode_now  = mode_sync_r;

  always @*
  begin
    stage_one_nxt = stage_one_r;
    stage_two_nxt = stage_two_r;
    if (clk_rise)
      stage_one_nxt = ready_req;
    // Mode taken fresh each falling edge so it can follow the bus cycle
    if (clk_fall)
      stage_two_nxt = stage_two_next(mode_now, stage_one_r,
                                     ready_req);
  end

  always @(posedge clk_sys)
  begin
    if (!nrst)
    begin
      stage_one_r <= `RIS_FF_RST;
      stage_two_r <= `RIS_FF_RST;
    end
    else
    begin
      stage_one_r <= stage_one_nxt;
      stage_two_r <= stage_two_nxt;
    end
  end

  assign ready_out = stage_two_r;

endmodule // ris_ready_sync

//--- ris_sva.sv
`timescale 1ns/10ps
module ris_sva (input wire clk_sys, nrst, proc_clk, ready_request_one,
  ready_request_two, ready_qualifier_one_n, ready_qualifier_two_n,
  sync_mode_select, ready_out);
  wire r = ready_request_one & ~ready_qualifier_one_n |
    ready_request_two & ~ready_qualifier_two_n;
  wire s = sync_mode_select;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!nrst);
  AST_SET: assert property ($fell(proc_clk) && !s && r
    && $past(r, 8) |-> ##5 ready_out[*3]) else $error("no set");
  AST_HOLD: assert property ($fell(proc_clk) && !s && r
    && !$past(r, 8) |-> ##5 (!ready_out)[*3]) else $error("early");
  AST_CLR: assert property ($fell(proc_clk) && !r
    |-> ##5 (!ready_out)[*3]) else $error("no clear");
  AST_ONE: assert property ($fell(proc_clk) && s && r
    |-> ##5 ready_out[*3]) else $error("no single");
  AST_STAND: assert property (proc_clk && $past(proc_clk, 3)
    |-> $stable(ready_out)) else $error("moved");
  AST_EDGE: assert property ($changed(ready_out)
    |-> $past(proc_clk, 4) && !$past(proc_clk, 3)) else $error("off edge");
endmodule // ris_sva
bind ris_ready_sync ris_sva u_sva (.clk_sys(clk_sys), .nrst(nrst),
  .proc_clk(proc_clk), .ready_request_one(ready_request_one),
  .ready_request_two(ready_request_two),
  .ready_qualifier_one_n(ready_qualifier_one_n),
  .ready_qualifier_two_n(ready_qualifier_two_n),
  .sync_mode_select(sync_mode_select), .ready_out(ready_out));

//--- ris_tb.sv
`timescale 1ns/10ps
module tb;
  reg clk_sys = 1'b0;
  reg nrst = 1'b0;
  reg [4:0] v = 5'h00;
  wire proc_clk, ready_out;
  integer miscompares = 0, compares = 0, cycles = 0;
  always #2 clk_sys = ~clk_sys;
  ris_peer peer (.clk_sys(clk_sys), .proc_clk(proc_clk));
  ris_ready_sync dut (.clk_sys(clk_sys), .nrst(nrst), .proc_clk(proc_clk),
    .ready_request_one(v[4]), .ready_qualifier_one_n(v[3]),
    .ready_request_two(v[2]), .ready_qualifier_two_n(v[1]),
    .sync_mode_select(v[0]), .ready_out(ready_out));
  task wrap_up;
    if (miscompares == 0 && compares > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task check(input got, input exp);
    begin
      compares = compares + 1;
      if (got !== exp)
        $display("unexpected %0t %h %h", $time, got, exp);
      miscompares = miscompares + (got !== exp);
    end
  endtask
  // Inputs move mid-phase, clear of the synchronizer's sampling
  task cyc(input [4:0] a, input [4:0] b, input e);
    @(negedge proc_clk);
    repeat (4) @(negedge clk_sys);
    v = a;
    @(posedge proc_clk);
    repeat (4) @(negedge clk_sys);
    v = b;
    @(negedge proc_clk);
    repeat (6) @(negedge clk_sys);
    check(ready_out, e);
  endtask
  always @(posedge clk_sys)
  begin
    cycles = cycles + 1;
    if (cycles == 2000)
      miscompares = miscompares + 1;
    if (cycles == 2000)
      wrap_up;
  end
  initial
  begin
    repeat (10) @(negedge clk_sys);
    nrst = 1'b1;
    cyc(5'h12, 5'h12, 1'b1);
    cyc(5'h02, 5'h12, 1'b0);
    cyc(5'h12, 5'h02, 1'b0);
    cyc(5'h03, 5'h13, 1'b1);
    cyc(5'h02, 5'h13, 1'b1);
    cyc(5'h13, 5'h12, 1'b1);
    cyc(5'h1e, 5'h1e, 1'b0);
    cyc(5'h04, 5'h04, 1'b1);
    wrap_up;
  end
endmodule // tb
